// ===== hw/cmpc_pkg.sv
package cmpc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONFIG_B      = 8'h2F;
  localparam logic [7:0] IDX_CTRL_STATUS_A = 8'h30;
  localparam logic [7:0] IDX_DIDR          = 8'h31;
  localparam logic [7:0] IDX_IRQ_STATUS    = 8'h32;
  localparam logic [7:0] IDX_IRQ_MASK      = 8'h33;
  localparam logic [7:0] IDX_CAPTURE_CTRL  = 8'h34;
  localparam int         ADDR_SHIFT        = 2;

  // comparator_control_status_a fields
  localparam int A_POWER_OFF   = 7;
  localparam int A_POS_SEL2    = 6;
  localparam int A_OUT_SYNC    = 5;
  localparam int A_EVENT_FLAG  = 4;
  localparam int A_IRQ_ENABLE  = 3;
  localparam int A_CAPT_ROUTE  = 2;
  localparam int A_MODE_HI     = 1;
  localparam int A_MODE_LO     = 0;
  localparam logic [7:0] A_RESET    = 8'h00;
  localparam logic [7:0] A_WR_MASK  = 8'hCF;

  // comparator_config_b fields
  localparam int B_HYST_SEL    = 7;
  localparam int B_HYST_LEVEL  = 6;
  localparam int B_NEG_SEL_HI  = 3;
  localparam int B_NEG_SEL_LO  = 2;
  localparam int B_POS_SEL1    = 1;
  localparam int B_POS_SEL0    = 0;
  localparam logic [7:0] B_RESET    = 8'h00;
  localparam logic [7:0] B_WR_MASK  = 8'hCF;

  // digital_input_disable_0 fields
  localparam int D_NEG_BUF_OFF = 2;
  localparam int D_POS_BUF_OFF = 1;
  localparam logic [7:0] D_RESET    = 8'h00;

  // interrupt status / mask layout
  localparam int I_CMP_EVENT   = 0;
  localparam int I_CAPTURE     = 1;
  localparam int I_WIDTH       = 2;

  // capture control fields
  localparam int C_NOISE_CANCEL = 0;
  localparam int C_EDGE_RISING  = 1;
  localparam int C_IRQ_ENABLE   = 2;
  localparam int C_FLAG         = 3;
  localparam logic [7:0] C_RESET     = 8'h00;

  // event mode codes
  localparam logic [1:0] MODE_TOGGLE   = 2'b00;
  localparam logic [1:0] MODE_RESERVED = 2'b01;
  localparam logic [1:0] MODE_FALLING  = 2'b10;
  localparam logic [1:0] MODE_RISING   = 2'b11;

  // input select codes
  localparam logic [1:0] NEG_PIN     = 2'b00;
  localparam logic [1:0] NEG_ADC_MUX = 2'b01;
  localparam logic [2:0] POS_PIN     = 3'b000;
  localparam logic [2:0] POS_BANDGAP = 3'b100;

  localparam int NOISE_SAMPLES = 4;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// ===== hw/cmpc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cmpc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             hclk,    // system clock
  input  wire logic             hresetn, // async reset, active low
  input  wire logic [WIDTH-1:0] d_async, // level from another domain
  output logic      [WIDTH-1:0] q_sync   // synchronised level
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // stage1 feeds stage2 only, to keep metastability contained
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= d_async;
      stage2_reg <= stage1_reg;
    end
  end

  assign q_sync = stage2_reg;
endmodule
`default_nettype wire

// ===== hw/cmpc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - raw result high when positive exceeds negative
// - result synchronised, 1-2 cycles, read only
// - flag set on selected output event
// - flag cleared by vector or write one
// - request needs flag, enable, global enable
// - modes: toggle, reserved, falling, rising
// - route bit feeds capture front end
// - capture interrupt needs timer capture enable
// - hysteresis enable; level 20 or 50 mV
// - negative select: pin, ADC mux, reserved
// - positive select: pin, bandgap, reserved
// - unused config bits read zero
// - negative pin buffer off, reads zero
// - positive pin buffer off, reads zero
// - disable bit powers comparator off
module cmpc_top
  import cmpc_pkg::*;
#(
  parameter int ADDR_W   = 8,
  parameter int NC_DEPTH = NOISE_SAMPLES
) (
  input  wire logic              hclk,                     // system clock
  input  wire logic              hresetn,                  // async reset, active low
  input  wire logic              hsel,                     // slave select
  input  wire logic [ADDR_W-1:0] haddr,                    // byte address
  input  wire logic [1:0]        htrans,                   // transfer type
  input  wire logic              hwrite,                   // write when high
  input  wire logic [2:0]        hsize,                    // transfer size, word only
  input  wire logic [31:0]       hwdata,                   // write data
  input  wire logic              hready,                   // bus ready in
  output logic                   hreadyout,                // slave ready
  output logic                   hresp,                    // response
  output logic      [31:0]       hrdata,                   // read data
  input  wire logic              comparator_raw,           // analog core result, async
  input  wire logic              pos_input_pin_raw,        // positive pin digital level
  input  wire logic              neg_input_pin_raw,        // negative pin digital level
  input  wire logic              capture_pin_raw,          // timer capture pin level
  input  wire logic              global_irq_enable,        // cpu status word I bit
  input  wire logic              cmp_vector_taken,         // comparator vector pulse
  input  wire logic              capture_vector_taken,     // capture vector pulse
  output logic                   comparator_power_off,     // power down analog core
  output logic                   hysteresis_enable,        // hysteresis on
  output logic                   hysteresis_level_50mv,    // 50 mV when high, else 20 mV
  output logic                   neg_sel_pin,              // negative from pin
  output logic                   neg_sel_adc_mux,          // negative from ADC mux
  output logic                   pos_sel_pin,              // positive from pin
  output logic                   pos_sel_bandgap,          // positive from bandgap
  output logic                   pos_pin_input_buffer_off, // positive pin buffer off
  output logic                   neg_pin_input_buffer_off, // negative pin buffer off
  output logic                   port_a_bit_one,           // port read of positive pin
  output logic                   port_a_bit_two,           // port read of negative pin
  output logic                   cmp_irq_request,          // comparator vector request
  output logic                   capture_trigger,          // capture edge pulse to timer
  output logic                   timer_capture_irq,        // timer capture request
  output logic                   irq                       // summary interrupt, level
);

  localparam logic [7:0] D_BITS = 8'((1 << D_NEG_BUF_OFF) | (1 << D_POS_BUF_OFF));

  // ---------------- registers ----------------
  logic [7:0]         ctrl_a_reg;
  logic [7:0]         config_b_reg;
  logic [7:0]         didr_reg;
  logic [7:0]         capt_ctrl_reg;
  logic [I_WIDTH-1:0] irq_status_reg;
  logic [I_WIDTH-1:0] irq_mask_reg;

  logic [31:0]        hrdata_reg;
  logic               wr_pend_reg;
  logic [ADDR_W-1:0]  wr_addr_reg;

  logic               out_prev_reg;
  logic [NC_DEPTH-1:0] nc_hist_reg;
  logic               nc_level_reg;
  logic               capt_prev_reg;
  logic               port_one_reg;
  logic               port_two_reg;

  // ---------------- synchronisers ----------------
  logic [3:0] sync_q;
  // bits are synchronised independently; no ordering between pins is kept

  cmpc_sync #(
    .WIDTH (4)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d_async ({capture_pin_raw,
               neg_input_pin_raw,
               pos_input_pin_raw,
               comparator_raw}),
    .q_sync  (sync_q)
  );

  // analog core drives high when positive input is above negative
  // power off forces the visible result low, which may itself be a falling event
  wire cmp_powered = ~ctrl_a_reg[A_POWER_OFF];
  wire cmp_sync   = sync_q[0] & cmp_powered;
  wire pos_pin_s  = sync_q[1];
  wire neg_pin_s  = sync_q[2];
  wire capt_pin_s = sync_q[3];

  // ---------------- bus decode ----------------
  wire              xfer      = hsel & htrans[1] & hready;
  wire              wr_take   = xfer & hwrite;
  wire              rd_take   = xfer & ~hwrite;
  wire [ADDR_W-1:0] rd_index  = haddr >> ADDR_SHIFT;
  wire [ADDR_W-1:0] wr_index  = wr_addr_reg >> ADDR_SHIFT;
  wire [7:0]        wdata     = hwdata[7:0];

  wire wr_a    = wr_pend_reg & (wr_index == ADDR_W'(IDX_CTRL_STATUS_A));
  wire wr_b    = wr_pend_reg & (wr_index == ADDR_W'(IDX_CONFIG_B));
  wire wr_d    = wr_pend_reg & (wr_index == ADDR_W'(IDX_DIDR));
  wire wr_mask = wr_pend_reg & (wr_index == ADDR_W'(IDX_IRQ_MASK));
  wire wr_capt = wr_pend_reg & (wr_index == ADDR_W'(IDX_CAPTURE_CTRL));

  wire rd_stat = rd_take & (rd_index == ADDR_W'(IDX_IRQ_STATUS));

  // ---------------- comparator event ----------------
  wire [1:0] mode    = {ctrl_a_reg[A_MODE_HI], ctrl_a_reg[A_MODE_LO]};
  wire       rise    = cmp_sync & ~out_prev_reg;
  wire       fall    = ~cmp_sync & out_prev_reg;
  logic      cmp_event;

  always_comb begin
    case (mode)
      MODE_TOGGLE:   cmp_event = rise | fall;
      MODE_RESERVED: cmp_event = 1'b0;
      MODE_FALLING:  cmp_event = fall;
      MODE_RISING:   cmp_event = rise;
      default:       cmp_event = 1'b0;
    endcase
  end

  // an event in the clearing cycle wins over the clear
  wire flag_clr  = cmp_vector_taken | (wr_a & wdata[A_EVENT_FLAG]);
  wire flag_next = (ctrl_a_reg[A_EVENT_FLAG] & ~flag_clr) | cmp_event;

  // mode changes cannot fake an edge; out_prev_reg tracks the output in every mode
  wire [7:0] ctrl_a_wr   = (wdata & A_WR_MASK) | {3'b000, flag_next, 4'h0};
  wire [7:0] ctrl_a_keep = {ctrl_a_reg[7:5], flag_next, ctrl_a_reg[3:0]};
  wire [7:0] ctrl_a_next = wr_a ? ctrl_a_wr : ctrl_a_keep;

  // ---------------- capture front end ----------------
  // route off means the comparator never reaches the capture path
  wire capt_src   = ctrl_a_reg[A_CAPT_ROUTE] ? cmp_sync : capt_pin_s;
  wire nc_all_hi  = &nc_hist_reg;
  wire nc_all_lo  = ~|nc_hist_reg;
  // the filter adds NC_DEPTH samples plus one edge of latency
  wire nc_next    = nc_all_hi ? 1'b1 : (nc_all_lo ? 1'b0 : nc_level_reg);
  wire capt_level = capt_ctrl_reg[C_NOISE_CANCEL] ? nc_level_reg : capt_src;
  wire capt_rise  = capt_level & ~capt_prev_reg;
  wire capt_fall  = ~capt_level & capt_prev_reg;
  wire capt_edge  = capt_ctrl_reg[C_EDGE_RISING] ? capt_rise : capt_fall;

  wire capt_clr  = capture_vector_taken | (wr_capt & wdata[C_FLAG]);
  wire capt_flag = (capt_ctrl_reg[C_FLAG] & ~capt_clr) | capt_edge;
  wire [7:0] capt_wr   = {4'h0, capt_flag, wdata[2:0]};
  wire [7:0] capt_keep = {4'h0, capt_flag, capt_ctrl_reg[2:0]};
  wire [7:0] capt_ctrl_next = wr_capt ? capt_wr : capt_keep;

  // ---------------- summary interrupt ----------------
  wire [I_WIDTH-1:0] irq_set    = {capt_edge, cmp_event};
  wire [I_WIDTH-1:0] irq_clr    = rd_stat ? {I_WIDTH{1'b1}} : {I_WIDTH{1'b0}};
  // a set in the clearing cycle survives the read
  wire [I_WIDTH-1:0] irq_status_next = (irq_status_reg & ~irq_clr)
                                       | irq_set;
  wire [I_WIDTH-1:0] irq_pending     = irq_status_reg & irq_mask_reg;

  // ---------------- read mux ----------------
  wire [7:0] ctrl_a_view = {ctrl_a_reg[7:6], cmp_sync, ctrl_a_reg[4:0]};
  wire [7:0] config_b_view = config_b_reg & B_WR_MASK;
  wire [7:0] didr_view     = didr_reg & D_BITS;
  wire [7:0] status_view   = 8'(irq_status_reg);
  wire [7:0] mask_view     = 8'(irq_mask_reg);
  logic [7:0] rd_byte;

  always_comb begin
    case (rd_index)
      ADDR_W'(IDX_CTRL_STATUS_A): rd_byte = ctrl_a_view;
      ADDR_W'(IDX_CONFIG_B):      rd_byte = config_b_view;
      ADDR_W'(IDX_DIDR):          rd_byte = didr_view;
      ADDR_W'(IDX_IRQ_STATUS):    rd_byte = status_view;
      ADDR_W'(IDX_IRQ_MASK):      rd_byte = mask_view;
      ADDR_W'(IDX_CAPTURE_CTRL):  rd_byte = capt_ctrl_reg;
      default:                    rd_byte = 8'h00;
    endcase
  end

  // ---------------- bus state ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      // a write lands one edge after its data phase opens
      wr_pend_reg <= wr_take;
      if (wr_take) begin
        wr_addr_reg <= haddr;
      end
      if (rd_take) begin
        hrdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_a_reg   <= A_RESET;
      config_b_reg <= B_RESET;
      didr_reg     <= D_RESET;
      irq_mask_reg <= '0;
    end else begin
      // the flag is rebuilt every cycle, so this register has no write enable
      ctrl_a_reg <= ctrl_a_next;
      if (wr_b) begin
        config_b_reg <= wdata & B_WR_MASK;
      end
      if (wr_d) begin
        didr_reg <= wdata & D_BITS;
      end
      if (wr_mask) begin
        irq_mask_reg <= wdata[I_WIDTH-1:0];
      end
    end
  end

  // ---------------- event and capture state ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_prev_reg   <= 1'b0;
      nc_hist_reg    <= '0;
      nc_level_reg   <= 1'b0;
      capt_prev_reg  <= 1'b0;
      capt_ctrl_reg  <= C_RESET;
      irq_status_reg <= '0;
    end else begin
      out_prev_reg   <= cmp_sync;
      nc_hist_reg    <= {nc_hist_reg[NC_DEPTH-2:0], capt_src};
      nc_level_reg   <= nc_next;
      capt_prev_reg  <= capt_level;
      capt_ctrl_reg  <= capt_ctrl_next;
      irq_status_reg <= irq_status_next;
    end
  end

  // ---------------- port pin readback ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_one_reg <= 1'b0;
      port_two_reg <= 1'b0;
    end else begin
      port_one_reg <= pos_pin_s & ~didr_reg[D_POS_BUF_OFF];
      port_two_reg <= neg_pin_s & ~didr_reg[D_NEG_BUF_OFF];
    end
  end

  // ---------------- analog controls ----------------
  wire [1:0] neg_code = {config_b_reg[B_NEG_SEL_HI], config_b_reg[B_NEG_SEL_LO]};
  wire [2:0] pos_code = {ctrl_a_reg[A_POS_SEL2], config_b_reg[B_POS_SEL1],
                         config_b_reg[B_POS_SEL0]};

  // reserved codes leave every source switch open
  assign neg_sel_pin     = (neg_code == NEG_PIN);
  assign neg_sel_adc_mux = (neg_code == NEG_ADC_MUX);
  assign pos_sel_pin     = (pos_code == POS_PIN);
  assign pos_sel_bandgap = (pos_code == POS_BANDGAP);

  assign comparator_power_off  = ctrl_a_reg[A_POWER_OFF];
  assign hysteresis_enable     = config_b_reg[B_HYST_SEL];
  assign hysteresis_level_50mv = config_b_reg[B_HYST_SEL] & config_b_reg[B_HYST_LEVEL];

  assign pos_pin_input_buffer_off = didr_reg[D_POS_BUF_OFF];
  assign neg_pin_input_buffer_off = didr_reg[D_NEG_BUF_OFF];
  assign port_a_bit_one           = port_one_reg;
  assign port_a_bit_two           = port_two_reg;

  // ---------------- interrupt outputs ----------------
  assign cmp_irq_request   = ctrl_a_reg[A_EVENT_FLAG]
                             & ctrl_a_reg[A_IRQ_ENABLE]
                             & global_irq_enable;
  assign capture_trigger   = capt_edge;
  assign timer_capture_irq = capt_ctrl_reg[C_FLAG] & capt_ctrl_reg[C_IRQ_ENABLE];
  assign irq               = |irq_pending;

  // ---------------- bus answers ----------------
  // zero wait states; sizes other than word are treated as word
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = hrdata_reg;

endmodule
`default_nettype wire

// ===== bench/cmpc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cmpc_properties (
  input wire logic hclk,                     // clock
  input wire logic hresetn,                  // reset, low
  input wire logic global_irq_enable,        // global enable
  input wire logic pos_input_pin_raw,        // pin level
  input wire logic neg_input_pin_raw,        // pin level
  input wire logic hysteresis_enable,        // hysteresis
  input wire logic hysteresis_level_50mv,    // level
  input wire logic neg_sel_pin,              // decode
  input wire logic neg_sel_adc_mux,          // decode
  input wire logic pos_sel_pin,              // decode
  input wire logic pos_sel_bandgap,          // decode
  input wire logic pos_pin_input_buffer_off, // buffer off
  input wire logic neg_pin_input_buffer_off, // buffer off
  input wire logic port_a_bit_one,           // port read
  input wire logic port_a_bit_two,           // port read
  input wire logic cmp_irq_request           // request
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // two cycles of buffer off: one for the register, one for the port flop
  sequence s_pos_off; pos_pin_input_buffer_off [*2]; endsequence
  sequence s_neg_off; neg_pin_input_buffer_off [*2]; endsequence
  a_hyst_level_gated: assert property (hysteresis_level_50mv |-> hysteresis_enable)
    else $error("level raised without hysteresis");
  a_neg_sel_single: assert property (!(neg_sel_pin && neg_sel_adc_mux))
    else $error("two negative sources");
  a_pos_sel_single: assert property (!(pos_sel_pin && pos_sel_bandgap))
    else $error("two positive sources");
  a_pos_port_zero: assert property (s_pos_off |-> !port_a_bit_one)
    else $error("positive port read not zero");
  a_neg_port_zero: assert property (s_neg_off |-> !port_a_bit_two)
    else $error("negative port read not zero");
  a_pos_port_lag: assert property (port_a_bit_one |->
    $past(pos_input_pin_raw, 2) || $past(pos_input_pin_raw, 3))
    else $error("positive port high without pin");
  a_neg_port_lag: assert property (port_a_bit_two |->
    $past(neg_input_pin_raw, 2) || $past(neg_input_pin_raw, 3))
    else $error("negative port high without pin");
  a_irq_global_gate: assert property (cmp_irq_request |-> global_irq_enable)
    else $error("request without global enable");
  cover property (s_pos_off);
endmodule
bind cmpc_top cmpc_properties u_props (.hclk, .hresetn, .global_irq_enable,
  .pos_input_pin_raw, .neg_input_pin_raw, .hysteresis_enable, .hysteresis_level_50mv,
  .neg_sel_pin, .neg_sel_adc_mux, .pos_sel_pin, .pos_sel_bandgap, .pos_pin_input_buffer_off,
  .neg_pin_input_buffer_off, .port_a_bit_one, .port_a_bit_two, .cmp_irq_request);
`default_nettype wire

// ===== bench/cmpc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmpc_analog_model #(
  parameter int BANDGAP_MV = 1000
) (
  input wire logic hclk,                  // scrambles an idle output
  input wire logic comparator_power_off,  // core off
  input wire logic hysteresis_enable,     // hysteresis on
  input wire logic hysteresis_level_50mv, // level
  input wire logic neg_sel_pin,           // negative from pin
  input wire logic neg_sel_adc_mux,       // negative from mux
  input wire logic pos_sel_pin,           // positive from pin
  input wire logic pos_sel_bandgap,       // positive from bandgap
  input var  int   pos_pin_mv,            // pin voltage
  input var  int   neg_pin_mv,            // pin voltage
  input var  int   adc_mux_mv,            // mux voltage
  output logic     comparator_raw         // result, async
);
  int h;
  int d;
  // launched on the falling edge so the result is unrelated to the sampling edge
  always @(negedge hclk) begin
    h = !hysteresis_enable ? 0 : hysteresis_level_50mv ? 50 : 20;
    d = (pos_sel_bandgap ? BANDGAP_MV : pos_pin_mv) -
      (neg_sel_adc_mux ? adc_mux_mv : neg_pin_mv);
    // unpowered or unrouted core gives no meaningful level, so it wanders
    if (comparator_power_off || !(pos_sel_pin || pos_sel_bandgap) ||
        !(neg_sel_pin || neg_sel_adc_mux))
      comparator_raw <= ~comparator_raw;
    else if (2 * d > h) comparator_raw <= 1'b1;
    else if (2 * d <= -h) comparator_raw <= 1'b0;
  end
endmodule
`default_nettype wire

// ===== bench/cmpc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module cmpc_top_test;
  import cmpc_pkg::*;
  localparam logic [7:0] AB = 8'(IDX_CONFIG_B << ADDR_SHIFT);
  localparam logic [7:0] AA = 8'(IDX_CTRL_STATUS_A << ADDR_SHIFT);
  localparam logic [7:0] AD = 8'(IDX_DIDR << ADDR_SHIFT);
  localparam logic [7:0] AS = 8'(IDX_IRQ_STATUS << ADDR_SHIFT);
  localparam logic [7:0] AM = 8'(IDX_IRQ_MASK << ADDR_SHIFT);
  localparam logic [7:0] AC = 8'(IDX_CAPTURE_CTRL << ADDR_SHIFT);
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic pos_input_pin_raw = 1'b0, neg_input_pin_raw = 1'b0, capture_pin_raw = 1'b0;
  logic global_irq_enable = 1'b0, cmp_vector_taken = 1'b0, capture_vector_taken = 1'b0;
  logic hready, hreadyout, hresp, comparator_raw, comparator_power_off, hysteresis_enable;
  logic hysteresis_level_50mv, neg_sel_pin, neg_sel_adc_mux, pos_sel_pin, pos_sel_bandgap;
  logic pos_pin_input_buffer_off, neg_pin_input_buffer_off, port_a_bit_one, port_a_bit_two;
  logic cmp_irq_request, capture_trigger, timer_capture_irq, irq;
  int pos_mv = 400, neg_mv = 500, adc_mv = 500, n_fail = 0, checks = 0, n_trig = 0;
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  always @(posedge hclk)
    if (capture_trigger === 1'b1) n_trig <= n_trig + 1;
  cmpc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .comparator_raw, .pos_input_pin_raw, .neg_input_pin_raw,
    .capture_pin_raw, .global_irq_enable, .cmp_vector_taken, .capture_vector_taken,
    .comparator_power_off, .hysteresis_enable, .hysteresis_level_50mv, .neg_sel_pin,
    .neg_sel_adc_mux, .pos_sel_pin, .pos_sel_bandgap, .pos_pin_input_buffer_off,
    .neg_pin_input_buffer_off, .port_a_bit_one, .port_a_bit_two, .cmp_irq_request,
    .capture_trigger, .timer_capture_irq, .irq);
  cmpc_analog_model far (.hclk, .comparator_power_off, .hysteresis_enable,
    .hysteresis_level_50mv, .neg_sel_pin, .neg_sel_adc_mux, .pos_sel_pin, .pos_sel_bandgap,
    .pos_pin_mv(pos_mv), .neg_pin_mv(neg_mv), .adc_mux_mv(adc_mv), .comparator_raw);
  task automatic ck(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1; htrans <= HTRANS_NONSEQ; haddr <= a; hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  // one idle edge after a write lets the new register value reach the outputs
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d); cyc(1);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 8'h00);
  endtask
  task automatic cmp(input logic v);
    pos_mv <= v ? 600 : 400; cyc(6);
  endtask
  task automatic t_reset;
    logic [7:0] r[7] = '{AB, AA, AD, AS, AM, AC, 8'hFC};
    ck("select reset", 2'b11, {neg_sel_pin, pos_sel_pin});
    ck("bus answer", 2'b10, {hreadyout, hresp});
    foreach (r[i]) begin
      rd(r[i]); ck("reset value", 32'h0, q);
    end
    $display("end reset");
  endtask
  task automatic t_sel;
    wr(AB, 8'hFF); rd(AB); ck("config_b", 32'hCF, q);
    ck("hyst 50", 2'b11, {hysteresis_enable, hysteresis_level_50mv});
    wr(AB, 8'h40); ck("hyst off", 2'b00, {hysteresis_enable, hysteresis_level_50mv});
    for (int c = 0; c < 4; c++) begin
      wr(AB, 8'(c << 2));
      ck("neg sel", c == 0 ? 2'b10 : c == 1 ? 2'b01 : 2'b00, {neg_sel_pin, neg_sel_adc_mux});
    end
    for (int c = 0; c < 8; c++) begin
      wr(AA, {1'b0, c[2], 6'h00}); wr(AB, {6'h00, c[1:0]});
      ck("pos sel", c == 0 ? 2'b10 : c == 4 ? 2'b01 : 2'b00, {pos_sel_pin, pos_sel_bandgap});
    end
    wr(AB, 8'h00); wr(AA, 8'h00);
    $display("end select");
  endtask
  task automatic t_events;
    logic e;
    for (int m = 0; m < 4; m++) begin
      wr(AA, 8'(m)); // interrupt stays disabled across the mode change
      for (int v = 1; v >= 0; v--) begin
        e = (m == 0) || (m == 3 && v == 1) || (m == 2 && v == 0);
        wr(AA, 8'(8'h10 | m)); cmp(v[0]); rd(AA);
        ck("event flag", e, q[A_EVENT_FLAG]);
        ck("synced out", v[0], q[A_OUT_SYNC]);
      end
    end
    $display("end events");
  endtask
  task automatic t_irq;
    wr(AA, 8'h10); global_irq_enable <= 1'b1; cmp(1);
    wr(AA, 8'h08); ck("request", 1, cmp_irq_request);
    global_irq_enable <= 1'b0; cyc(1); ck("no global", 0, cmp_irq_request);
    global_irq_enable <= 1'b1; cmp_vector_taken <= 1'b1; cyc(1);
    cmp_vector_taken <= 1'b0; cyc(1); ck("vector clear", 0, cmp_irq_request);
    cmp(0); ck("request again", 1, cmp_irq_request);
    wr(AA, 8'h18); ck("w1c clear", 0, cmp_irq_request);
    cmp(1); wr(AA, 8'h00); ck("disabled", 0, cmp_irq_request);
    rd(AA); ck("flag kept", 1, q[A_EVENT_FLAG]);
    wr(AA, 8'h10); rd(AS); wr(AM, 8'h01); cmp(0); ck("irq", 1, irq);
    wr(AM, 8'h00); ck("irq masked", 0, irq);
    wr(AM, 8'h01); rd(AS); ck("status", 32'h1, q); ck("irq read clear", 0, irq);
    rd(AS); ck("status cleared", 32'h0, q);
    wr(AM, 8'h00);
    $display("end interrupt");
  endtask
  task automatic t_capture;
    int t0;
    t0 = n_trig;
    wr(AC, 8'h0A); wr(AA, 8'h04); cmp(1); rd(AC);
    ck("capture flag", 1, q[C_FLAG]); ck("no enable", 0, timer_capture_irq);
    wr(AC, 8'h06); ck("capture irq", 1, timer_capture_irq);
    capture_vector_taken <= 1'b1; cyc(1); capture_vector_taken <= 1'b0; cyc(2);
    ck("capture vector", 0, timer_capture_irq);
    wr(AA, 8'h00); cmp(0); cmp(1); ck("route off", 0, timer_capture_irq);
    capture_pin_raw <= 1'b1; cyc(6); ck("pin capture", 1, timer_capture_irq);
    capture_pin_raw <= 1'b0; cyc(6); wr(AC, 8'h0F); cyc(10);
    ck("falling ignored", 0, timer_capture_irq);
    capture_pin_raw <= 1'b1; cyc(3); ck("filter delay", 0, timer_capture_irq);
    cyc(8); ck("filtered edge", 1, timer_capture_irq);
    ck("trigger count", t0 + 3, n_trig);
    wr(AC, 8'h08);
    $display("end capture");
  endtask
  task automatic t_pins;
    pos_input_pin_raw <= 1'b1; neg_input_pin_raw <= 1'b1; cyc(5);
    ck("ports on", 2'b11, {port_a_bit_one, port_a_bit_two});
    wr(AD, 8'h06); cyc(1); ck("ports off", 2'b00, {port_a_bit_one, port_a_bit_two});
    ck("buffers off", 2'b11, {pos_pin_input_buffer_off, neg_pin_input_buffer_off});
    rd(AD); ck("didr", 32'h06, q);
    wr(AD, 8'h02); cyc(1); ck("pos off", 2'b01, {port_a_bit_one, port_a_bit_two});
    wr(AD, 8'h00);
    $display("end pins");
  endtask
  task automatic t_power;
    wr(AA, 8'h80); ck("power off", 1, comparator_power_off);
    cmp(1); rd(AA); ck("out gated", 0, q[A_OUT_SYNC]);
    wr(AA, 8'h00); ck("power on", 0, comparator_power_off);
    $display("end power");
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    cyc(3);
    hresetn <= 1'b1;
    cyc(1);
    t_reset; t_sel; t_events; t_irq; t_capture; t_pins; t_power;
    test_done;
  end
  // the sequence needs well under 2000 cycles
  initial begin
    #40000;
    n_fail++;
    test_done;
  end
endmodule
`default_nettype wire
